// *** adsq_pkg.sv ***
// Purpose: Shared constants and types for the converter sequencing control.
// Assumes: One 40 MHz system clock; control bits arrive as plain ports.
// Notes:   Times are kept in their own units and turned into cycle counts here.
package adsq_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned CONV_CLK_MAX_HZ   = 10_000_000;
  localparam int unsigned VREF_SETTLE_NS    = 1000;
  localparam int unsigned SAMPLE_CYCLES     = 3;
  // Least time rounds up to whole cycles.
  localparam int unsigned VREF_SETTLE_CYC   =
    (VREF_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // System-clock divide at the conversion clock limit, rounded up; the divider toggles once per count, so this holds it at half the limit.
  localparam int unsigned CONV_DIV_MIN      = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;

  // ==========================================================================
  // Widths and resolutions
  // ==========================================================================
  localparam int unsigned RES_W             = 10;
  localparam int unsigned CODES_10BIT       = 1024;
  localparam int unsigned CODES_8BIT        = 256;
  localparam int unsigned CH_W              = 3;
  localparam int unsigned DIV_W             = 4;
  localparam int unsigned CNT_W             = 8;
  localparam logic [RES_W-1:0] RES_ZERO     = 10'h000;

  typedef enum logic [1:0] {
    ADSQ_MODE_ONE_SHOT,
    ADSQ_MODE_SINGLE_SWEEP,
    ADSQ_MODE_REPEAT,
    ADSQ_MODE_REPEAT_SWEEP
  } adsq_mode_t;

  // Control bits set by software.
  typedef struct packed {
    adsq_mode_t            mode;
    logic                  ten_bit;
    logic                  vref_on;
    logic [CH_W-1:0]       channel;
    logic [DIV_W-1:0]      clk_div;
  } adsq_ctrl_t;

  // Status shown to software.
  typedef struct packed {
    logic                  busy;
    logic                  irq_req;
    logic                  result_invalid;
    logic                  vref_ready;
    logic                  chan_stale;
    logic                  div_error;
  } adsq_stat_t;

endpackage : adsq_pkg

// *** adsq_ctrl.sv ***
// Purpose: Sequencing for an on-chip A/D converter: settle wait, sampling, result, request bit.
// Assumes: The analog core delivers a code on conv_data_in with conv_data_valid as a pulse.
// Notes:   Control is frozen while en is low; outputs come from flip-flops.
//          Software-side rules are listed for reference; the block enforces only what it can.
//          A start that breaks a rule is dropped silently, so software must watch busy.
//
// Contract
// - Completion is flagged by the request bit; results read after it.
// - An aborted conversion may leave results indeterminate.
// - Converter offers ten-bit 1024-code and eight-bit 256-code modes.
// - Sampling lasts three conversion clock cycles with sample-and-hold.
`timescale 1ns/1ps
module adsq_ctrl #(
  parameter int unsigned SAMPLE_N = adsq_pkg::SAMPLE_CYCLES
) (
  // Clock, reset and enable
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     en,
  // Software control
  input  wire adsq_pkg::adsq_ctrl_t     ctrl,
  input  wire logic                     start,
  input  wire logic                     stop,
  input  wire logic                     chan_write,
  input  wire logic                     irq_clear,
  // Analog core
  input  wire logic [adsq_pkg::RES_W-1:0] conv_data_in,
  input  wire logic                     conv_data_valid,
  output logic                          sample_ff,
  output logic                          convert_ff,
  output logic                          conv_clk_ff,
  // Result and status
  output logic [adsq_pkg::RES_W-1:0]    result_ff,
  output adsq_pkg::adsq_stat_t          stat_ff
);
  import adsq_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adsq_state_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [RES_W-1:0] fit_res(input logic [RES_W-1:0] d, input logic ten);
    fit_res = ten ? d : {2'h0, d[RES_W-1:2]};
  endfunction : fit_res

  function automatic logic single_mode(input adsq_mode_t m);
    single_mode = (m == ADSQ_MODE_ONE_SHOT) || (m == ADSQ_MODE_SINGLE_SWEEP);
  endfunction : single_mode

  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(VREF_SETTLE_CYC);
  localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(SAMPLE_N);
  localparam logic [DIV_W-1:0] DIV_MIN    = DIV_W'(CONV_DIV_MIN);

  adsq_state_t          state_ff, nxt_state;
  logic [CNT_W-1:0]     settle_ff, nxt_settle;
  logic [CNT_W-1:0]     samp_ff, nxt_samp;
  logic [DIV_W-1:0]     div_ff, nxt_div;
  logic                 nxt_conv_clk, nxt_sample, nxt_convert;
  logic                 vref_q_ff, nxt_vref_q;
  adsq_mode_t           mode_q_ff, nxt_mode_q;
  logic [RES_W-1:0]     nxt_result;
  adsq_stat_t           nxt_stat;
  logic                 tick;
  logic [DIV_W-1:0]     div_eff;

  // ==========================================================================
  // Conversion clock divider
  // ==========================================================================
  // The divide is clamped rather than refused, so a bad setting never overclocks the core.
  always_comb begin
    div_eff      = (ctrl.clk_div < DIV_MIN) ? DIV_MIN : ctrl.clk_div;
    tick         = (div_ff == DIV_W'(0));
    nxt_div      = tick ? div_eff - DIV_W'(1) : div_ff - DIV_W'(1);
    nxt_conv_clk = tick ? ~conv_clk_ff : conv_clk_ff;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff      <= '0;
      conv_clk_ff <= 1'b0;
    end else if (en) begin
      div_ff      <= nxt_div;
      conv_clk_ff <= nxt_conv_clk;
    end
  end

  // ==========================================================================
  // Reference settle timer
  // ==========================================================================
  // Settle counter restarts on each rising edge of the reference connection.
  always_comb begin
    nxt_vref_q = ctrl.vref_on;
    nxt_settle = settle_ff;
    if (!ctrl.vref_on) begin
      nxt_settle = SETTLE_CNT;
    end else if (!vref_q_ff) begin
      nxt_settle = SETTLE_CNT;
    end else if (settle_ff != CNT_W'(0)) begin
      nxt_settle = settle_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_ff <= '0;
      vref_q_ff <= 1'b0;
    end else if (en) begin
      settle_ff <= nxt_settle;
      vref_q_ff <= nxt_vref_q;
    end
  end

  // ==========================================================================
  // Sequencer next-state logic
  // ==========================================================================
  always_comb begin
    nxt_state    = state_ff;
    nxt_samp     = samp_ff;
    nxt_result   = result_ff;
    nxt_stat     = stat_ff;
    nxt_mode_q   = ctrl.mode;
    nxt_stat.div_error = (ctrl.clk_div < DIV_MIN);
    nxt_stat.vref_ready = ctrl.vref_on && vref_q_ff && (settle_ff == CNT_W'(0));
    // Channel must be rewritten after a mode change.
    if (ctrl.mode != mode_q_ff) begin
      nxt_stat.chan_stale = 1'b1;
    end else if (chan_write) begin
      nxt_stat.chan_stale = 1'b0;
    end
    if (irq_clear) begin
      nxt_stat.irq_req = 1'b0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        // A start before the reference has settled or with a stale channel is ignored.
        if (start && stat_ff.vref_ready && !stat_ff.chan_stale) begin
          nxt_state = ST_SAMPLE;
          nxt_samp  = SAMPLE_CNT;
          nxt_stat.result_invalid = 1'b0;
        end
      end
      ST_SAMPLE: begin
        if (stop) begin
          nxt_state = ST_IDLE;
          nxt_stat.result_invalid = 1'b1;
        end else if (tick && conv_clk_ff) begin
          // One conversion clock period counted per falling phase.
          if (samp_ff == CNT_W'(1)) begin
            nxt_state = ST_CONVERT;
          end
          nxt_samp = samp_ff - CNT_W'(1);
        end
      end
      ST_CONVERT: begin
        if (stop) begin
          nxt_state = ST_IDLE;
          nxt_stat.result_invalid = 1'b1;
        end else if (conv_data_valid) begin
          nxt_result = fit_res(conv_data_in, ctrl.ten_bit);
          if (single_mode(ctrl.mode)) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_SAMPLE;
            nxt_samp  = SAMPLE_CNT;
          end
          // Request bit is set in the same cycle as the result; set wins over clear.
          nxt_stat.irq_req = 1'b1;
        end
      end
    endcase
    nxt_sample    = (nxt_state == ST_SAMPLE);
    nxt_convert   = (nxt_state == ST_CONVERT);
    nxt_stat.busy = (nxt_state != ST_IDLE);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= ST_IDLE;
      samp_ff     <= '0;
      sample_ff   <= 1'b0;
      convert_ff  <= 1'b0;
      mode_q_ff   <= ADSQ_MODE_ONE_SHOT;
      result_ff   <= RES_ZERO;
      stat_ff     <= '0;
    end else if (en) begin
      state_ff    <= nxt_state;
      samp_ff     <= nxt_samp;
      sample_ff   <= nxt_sample;
      convert_ff  <= nxt_convert;
      mode_q_ff   <= nxt_mode_q;
      result_ff   <= nxt_result;
      stat_ff     <= nxt_stat;
    end
  end

endmodule : adsq_ctrl

// *** adsq_chk.sv ***
// Purpose: Port-level checks for the converter sequencing control.
// Assumes: One clock domain; conversion divide at its smallest legal value.
// Notes:   Sampling bound leaves slack for the conversion clock phase.
`timescale 1ns/1ps
module adsq_chk
  import adsq_pkg::*;
#(
  parameter int unsigned SAMPLE_N = SAMPLE_CYCLES
) (
  // Control inputs
  input wire logic             clk, arst_n, en, start, stop, chan_write, irq_clear,
  input wire adsq_ctrl_t       ctrl,
  input wire logic [RES_W-1:0] conv_data_in,
  input wire logic             conv_data_valid,
  // Observed outputs
  input wire logic             sample_ff, convert_ff, conv_clk_ff,
  input wire logic [RES_W-1:0] result_ff,
  input wire adsq_stat_t       stat_ff
);
  logic [7:0] vref_cnt_ff, samp_cnt_ff;
  // Counters saturate or clear so that long runs never wrap into a false pass.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vref_cnt_ff <= 8'h00;
      samp_cnt_ff <= 8'h00;
    end else begin
      vref_cnt_ff <= !ctrl.vref_on ? 8'h00 : vref_cnt_ff + {7'h00, vref_cnt_ff != 8'hFF};
      samp_cnt_ff <= sample_ff ? samp_cnt_ff + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_VREF_WAIT: assert property (stat_ff.vref_ready |-> vref_cnt_ff >= VREF_SETTLE_CYC)
    else $error("reference ready too early");
  AST_START_OK: assert property (en && start && !stop && !stat_ff.busy && stat_ff.vref_ready
    && !stat_ff.chan_stale |=> sample_ff && stat_ff.busy) else $error("start not taken");
  AST_START_REFUSED: assert property (start && !stat_ff.busy
    && (stat_ff.chan_stale || !stat_ff.vref_ready) |=> !stat_ff.busy) else $error("start taken");
  AST_RES_TEN: assert property (en && convert_ff && conv_data_valid && ctrl.ten_bit
    |=> result_ff == $past(conv_data_in) && stat_ff.irq_req) else $error("ten-bit result");
  AST_RES_EIGHT: assert property (en && convert_ff && conv_data_valid && !ctrl.ten_bit
    |=> result_ff == ($past(conv_data_in) >> 2)) else $error("eight-bit result");
  AST_IRQ_CAUSE: assert property ($rose(stat_ff.irq_req)
    |-> $past(conv_data_valid) && $past(convert_ff)) else $error("request without result");
  AST_ABORT: assert property (en && stop && stat_ff.busy
    |=> !stat_ff.busy && stat_ff.result_invalid) else $error("abort not flagged");
  AST_CCLK_RATE: assert property ($changed(conv_clk_ff) |=> $stable(conv_clk_ff))
    else $error("conversion clock too fast");
  AST_DIV_FLAG: assert property ((en && ctrl.clk_div < 4'h2) [*3] |-> stat_ff.div_error)
    else $error("divide error missing");
  AST_SAMPLE_LEN: assert property ($fell(sample_ff) && !$past(stop)
    |-> samp_cnt_ff >= 4 * SAMPLE_N - 3) else $error("sampling too short");
endmodule : adsq_chk

bind adsq_ctrl adsq_chk #(.SAMPLE_N(SAMPLE_N)) u_chk (.clk(clk), .arst_n(arst_n), .en(en),
  .start(start), .stop(stop), .chan_write(chan_write), .irq_clear(irq_clear), .ctrl(ctrl),
  .conv_data_in(conv_data_in), .conv_data_valid(conv_data_valid), .sample_ff(sample_ff),
  .convert_ff(convert_ff), .conv_clk_ff(conv_clk_ff), .result_ff(result_ff), .stat_ff(stat_ff));

// *** adsq_tb.sv ***
// Purpose: Directed bench for the converter sequencing control.
// Assumes: Inputs change on the falling edge only.
// Notes:   Each mode runs to one result; one-shot is first started and aborted once, and repeat modes are ended by an abort.
`timescale 1ns/1ps
module testbench;
  import adsq_pkg::*;
  logic             clk, arst_n, en, start, stop, chan_write, irq_clear, conv_data_valid;
  logic             sample_ff, convert_ff, conv_clk_ff;
  logic [RES_W-1:0] conv_data_in, result_ff, d;
  adsq_ctrl_t       ctrl;
  adsq_stat_t       stat_ff;
  int               err_count, n_tests;
  adsq_ctrl dut (.clk(clk), .arst_n(arst_n), .en(en), .ctrl(ctrl), .start(start), .stop(stop),
    .chan_write(chan_write), .irq_clear(irq_clear), .conv_data_in(conv_data_in),
    .conv_data_valid(conv_data_valid), .sample_ff(sample_ff), .convert_ff(convert_ff),
    .conv_clk_ff(conv_clk_ff), .result_ff(result_ff), .stat_ff(stat_ff));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask : pulse
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
  initial begin
    {arst_n, start, stop, chan_write, irq_clear, conv_data_valid} = 6'h00;
    en = 1'h1;
    conv_data_in = 10'h000;
    ctrl = '{ADSQ_MODE_ONE_SHOT, 1'h1, 1'h0, 3'h0, 4'h2};
    repeat (2) @(negedge clk);
    arst_n = 1'h1;
    check(stat_ff, 6'h00);
    pulse(start);
    check(stat_ff.busy, 1'h0);
    ctrl.vref_on = 1'h1;
    repeat (45) @(negedge clk);
    check(stat_ff.vref_ready, 1'h1);
    for (int m = 0; m < 4; m++) begin
      ctrl.mode = adsq_mode_t'(m);
      ctrl.ten_bit = m[0];
      d = m[1] ? 10'h3FF : 10'h2AD;
      @(negedge clk);
      check(stat_ff.chan_stale, m != 0);
      pulse(start);
      check(stat_ff.busy, m == 0);
      if (m == 0) pulse(stop);
      pulse(chan_write);
      pulse(start);
      check(stat_ff.busy, 1'h1);
      for (int i = 0; i < 300 && !convert_ff; i++) @(negedge clk);
      check(stat_ff.irq_req, 1'h0);
      conv_data_in = d;
      pulse(conv_data_valid);
      check(result_ff, m[0] ? d : {2'h0, d[9:2]});
      check(stat_ff.irq_req, 1'h1);
      check(stat_ff.busy, m[1]);
      pulse(irq_clear);
      check(stat_ff.irq_req, 1'h0);
      for (int i = 0; i < 8 && !sample_ff; i++) @(negedge clk);
      check(sample_ff, m[1]);
      if (m[1]) pulse(stop);
      check(stat_ff.busy, 1'h0);
      if (m[1]) check(stat_ff.result_invalid, 1'h1);
    end
    ctrl.clk_div = 4'h1;
    repeat (4) @(negedge clk);
    check(stat_ff.div_error, 1'h1);
    final_report();
  end
endmodule : testbench
